/* pkg/rssi_test_fifo_status_regs_defs.vh */
// constants for the strength, test and fifo status register group
// assumes a 25 MHz system clock and word-aligned ahb-lite access
`ifndef RSSI_TEST_FIFO_STATUS_REGS_DEFS_VH
`define RSSI_TEST_FIFO_STATUS_REGS_DEFS_VH

// register indices and byte addresses (index times four)
`define IDX_STRENGTH_OSC 8'h0f
`define IDX_ANALOG_TEST 8'h1a
`define IDX_DIGITAL_TEST 8'h1b
`define IDX_FIFO_FILL 8'h1c
`define ADDR_WORD_SHIFT 2
`define ADDR_IDX_MSB 9

// strength and oscillator status fields
`define SOS_OSC_OK_BIT 6
`define SOS_AUX_MSB 5
`define SOS_AUX_LSB 3
`define SOS_MAIN_MSB 2
`define SOS_MAIN_LSB 0

// analog test control fields
`define ATC_KEYING_IN_BIT 7
`define ATC_SUBC_OUT_BIT 6
`define ATC_DIRECT_MOD_BIT 5
`define ATC_STAGE_SEL_BIT 4
`define ATC_SECOND_ATT_BIT 3
`define ATC_FIRST_ATT_BIT 2
`define ATC_FOLLOWER_BIT 1
`define ATC_AGC_OBS_BIT 0
`define ATC_RESET 8'h00

// digital test control fields
`define DTC_RF_AMP_BIT 7
`define DTC_IO_HIGH_BIT 3
`define DTC_IO_LOW_BIT 2
`define DTC_DEC_TEST_BIT 1
`define DTC_FAST_CLK_BIT 0
`define DTC_WR_MASK 8'h8f
`define DTC_STOP_CLR_MASK 8'h0e
`define DTC_RESET 8'h00

// fifo fill status fields and levels
`define FFS_HIGH_BIT 6
`define FFS_LOW_BIT 5
`define FFS_OVF_BIT 4
`define FIFO_CAPACITY 5'd16
`define FIFO_HIGH_LEVEL 5'd9
`define FIFO_LOW_LEVEL 5'd3

// timing
`define CLK_MHZ 25
`define OSC_SETTLE_US 200
`define OSC_SETTLE_CYC (`OSC_SETTLE_US * `CLK_MHZ)

`endif

/* hw/rssi_test_fifo_status_regs.v */
// strength/oscillator status, two test registers and fifo fill status
// assumes framing events and levels come from logic on i_clk_sys,
// pins and the enable input are asynchronous, one ahb-lite master
//
// Local design decision: register access over AHB-Lite.
`include "rssi_test_fifo_status_regs_defs.vh"

module rssi_test_fifo_status_regs #(
    parameter OSC_SETTLE_CYC = `OSC_SETTLE_CYC
) (
    // clock and reset
    input wire i_clk_sys,
    input wire i_rst_b,
    // device enable pin
    input wire i_enable,
    // ahb-lite slave
    input wire i_hsel,
    input wire [31:0] i_haddr,
    input wire [1:0] i_htrans,
    input wire i_hwrite,
    input wire [2:0] i_hsize,
    input wire [31:0] i_hwdata,
    input wire i_hready,
    output reg [31:0] o_hrdata_ff,
    output reg o_hreadyout_ff,
    output reg o_hresp_ff,
    // framing events
    input wire i_tx_start,
    input wire i_tx_active,
    input wire i_rx_active,
    input wire i_rf_amp_cmd,
    input wire i_stop_cond,
    input wire i_swap_inputs,
    // measured levels
    input wire [2:0] i_in1_env_lvl,
    input wire [2:0] i_in2_env_lvl,
    input wire [2:0] i_rf_amp_lvl,
    input wire [2:0] i_agc_lvl,
    // fifo activity
    input wire i_fifo_push,
    input wire i_fifo_pop,
    input wire i_fifo_reset,
    // subcarrier paths and pins
    input wire i_keying_pin,
    input wire i_mod_pin,
    input wire i_demod_subcarrier,
    input wire i_rx_subcarrier,
    output reg o_decoder_in_ff,
    output reg o_mod_pin_out_ff,
    output reg o_mod_pin_oe_ff,
    output reg o_tx_mod_ff,
    // analog controls
    output reg o_direct_modulation_select_ff,
    output reg o_rx_reset_ff,
    output reg o_stage_sel_ff,
    output reg o_second_stage_attenuate_ff,
    output reg o_first_stage_attenuate_ff,
    output reg o_follower_test_ff,
    // digital test controls
    output reg o_rf_amplitude_test_ff,
    output reg o_io_test_high_ff,
    output reg o_io_test_low_ff,
    output reg o_decoder_test_ff,
    output reg o_test_mode_ff,
    output reg o_coder_fast_clock_ff,
    // status
    output reg o_strength_valid_ff,
    output reg o_osc_ok_ff,
    output reg o_fifo_irq_set_ff
);

    // peak of two 3-bit strength codes
    function [2:0] peak3;
        input [2:0] a;
        input [2:0] b;
        begin
            peak3 = (a > b) ? a : b;
        end
    endfunction

    // synchronisers
    reg en_meta_ff;
    reg en_sync_ff;
    reg key_meta_ff;
    reg key_sync_ff;
    reg mod_meta_ff;
    reg mod_sync_ff;

    always @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            en_meta_ff <= 1'b0;
            en_sync_ff <= 1'b0;
            key_meta_ff <= 1'b0;
            key_sync_ff <= 1'b0;
            mod_meta_ff <= 1'b0;
            mod_sync_ff <= 1'b0;
        end else begin
            en_meta_ff <= i_enable;
            en_sync_ff <= en_meta_ff;
            key_meta_ff <= i_keying_pin;
            key_sync_ff <= key_meta_ff;
            mod_meta_ff <= i_mod_pin;
            mod_sync_ff <= mod_meta_ff;
        end
    end

    wire dev_off = ~en_sync_ff;

    // ahb address phase capture
    wire addr_phase = i_hsel & i_htrans[1] & i_hready;
    wire [7:0] addr_idx = i_haddr[`ADDR_IDX_MSB:`ADDR_WORD_SHIFT];
    reg wr_pend_ff;
    reg [7:0] wr_idx_ff;

    always @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_pend_ff <= 1'b0;
            wr_idx_ff <= 8'h00;
        end else begin
            wr_pend_ff <= addr_phase & i_hwrite;
            wr_idx_ff <= addr_phase ? addr_idx : wr_idx_ff;
        end
    end

    wire wr_data = wr_pend_ff;

    // test registers
    reg [7:0] atest_ff;
    reg [7:0] dtest_ff;
    reg [7:0] nxt_atest;
    reg [7:0] nxt_dtest;

    always @* begin
        nxt_atest = atest_ff;
        nxt_dtest = dtest_ff;
        if (i_stop_cond) begin
            nxt_dtest = dtest_ff & ~`DTC_STOP_CLR_MASK;
        end
        if (wr_data && wr_idx_ff == `IDX_ANALOG_TEST) begin
            nxt_atest = i_hwdata[7:0];
        end
        if (wr_data && wr_idx_ff == `IDX_DIGITAL_TEST) begin
            nxt_dtest = i_hwdata[7:0] & `DTC_WR_MASK;
        end
        if (dev_off) begin
            nxt_atest = `ATC_RESET;
            nxt_dtest = `DTC_RESET;
        end
    end

    always @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            atest_ff <= `ATC_RESET;
            dtest_ff <= `DTC_RESET;
        end else begin
            atest_ff <= nxt_atest;
            dtest_ff <= nxt_dtest;
        end
    end

    // strength peak latches
    reg [2:0] main_peak_ff;
    reg [2:0] aux_peak_ff;
    reg valid_ff;
    reg [2:0] nxt_main_peak;
    reg [2:0] nxt_aux_peak;
    reg nxt_valid;
    reg [2:0] main_src;
    reg [2:0] aux_src;

    always @* begin
        main_src = i_swap_inputs ? i_in2_env_lvl : i_in1_env_lvl;
        aux_src = i_swap_inputs ? i_in1_env_lvl : i_in2_env_lvl;
        if (i_rf_amp_cmd) begin
            main_src = i_rf_amp_lvl;
        end
        nxt_main_peak = main_peak_ff;
        nxt_aux_peak = aux_peak_ff;
        nxt_valid = valid_ff;
        if (i_rx_active || i_rf_amp_cmd) begin
            nxt_main_peak = peak3(main_peak_ff, main_src);
            nxt_aux_peak = peak3(aux_peak_ff, aux_src);
        end
        if (i_rx_active) begin
            nxt_valid = 1'b1;
        end
        if (i_tx_start || dev_off) begin
            nxt_main_peak = 3'h0;
            nxt_aux_peak = 3'h0;
            nxt_valid = 1'b0;
        end
    end

    always @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            main_peak_ff <= 3'h0;
            aux_peak_ff <= 3'h0;
            valid_ff <= 1'b0;
        end else begin
            main_peak_ff <= nxt_main_peak;
            aux_peak_ff <= nxt_aux_peak;
            valid_ff <= nxt_valid;
        end
    end

    // oscillator settle counter
    reg [15:0] osc_cnt_ff;
    reg osc_ok_ff;
    wire [15:0] osc_target = OSC_SETTLE_CYC[15:0];

    always @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            osc_cnt_ff <= 16'h0000;
            osc_ok_ff <= 1'b0;
        end else if (dev_off) begin
            osc_cnt_ff <= 16'h0000;
            osc_ok_ff <= 1'b0;
        end else if (!osc_ok_ff) begin
            osc_cnt_ff <= osc_cnt_ff + 16'h0001;
            osc_ok_ff <= (osc_cnt_ff + 16'h0001 >= osc_target);
        end
    end

    // fifo fill tracking
    reg [4:0] fill_ff;
    reg ovf_ff;
    reg high_ff;
    reg low_ff;
    reg [4:0] nxt_fill;
    reg nxt_ovf;
    reg nxt_high;
    reg nxt_low;

    always @* begin
        nxt_fill = fill_ff;
        nxt_ovf = ovf_ff;
        if (i_fifo_push && !i_fifo_pop) begin
            if (fill_ff == `FIFO_CAPACITY) begin
                nxt_ovf = 1'b1;
            end else begin
                nxt_fill = fill_ff + 5'd1;
            end
        end else if (i_fifo_pop && !i_fifo_push && fill_ff != 5'd0) begin
            nxt_fill = fill_ff - 5'd1;
        end else if (i_fifo_pop && i_fifo_push && fill_ff == 5'd0) begin
            nxt_fill = 5'd1;
        end
        if (i_fifo_reset || dev_off) begin
            nxt_fill = 5'd0;
            nxt_ovf = 1'b0;
        end
        nxt_high = i_rx_active && (nxt_fill >= `FIFO_HIGH_LEVEL);
        nxt_low = i_tx_active && (nxt_fill <= `FIFO_LOW_LEVEL);
    end

    always @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fill_ff <= 5'd0;
            ovf_ff <= 1'b0;
            high_ff <= 1'b0;
            low_ff <= 1'b0;
        end else begin
            fill_ff <= nxt_fill;
            ovf_ff <= nxt_ovf;
            high_ff <= nxt_high;
            low_ff <= nxt_low;
        end
    end

    // status register images
    reg [7:0] sos_img;
    reg [7:0] ffs_img;
    reg [7:0] rd_byte;
    reg [3:0] unread_m1;

    always @* begin
        sos_img = 8'h00;
        sos_img[`SOS_OSC_OK_BIT] = osc_ok_ff;
        sos_img[`SOS_AUX_MSB:`SOS_AUX_LSB] = aux_peak_ff;
        sos_img[`SOS_MAIN_MSB:`SOS_MAIN_LSB] = main_peak_ff;
        if (atest_ff[`ATC_AGC_OBS_BIT]) begin
            sos_img[`SOS_MAIN_MSB:`SOS_MAIN_LSB] = i_agc_lvl;
        end
        unread_m1 = (fill_ff == 5'd0) ? 4'h0 : fill_ff[3:0] - 4'h1;
        ffs_img = {1'b0, high_ff, low_ff, ovf_ff, unread_m1};
        case (addr_idx)
            `IDX_STRENGTH_OSC: rd_byte = sos_img;
            `IDX_ANALOG_TEST: rd_byte = nxt_atest;
            `IDX_DIGITAL_TEST: rd_byte = nxt_dtest;
            `IDX_FIFO_FILL: rd_byte = ffs_img;
            default: rd_byte = 8'h00;
        endcase
    end

    // ahb response, zero wait, always okay
    always @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_hrdata_ff <= 32'h00000000;
            o_hreadyout_ff <= 1'b0;
            o_hresp_ff <= 1'b0;
        end else begin
            o_hreadyout_ff <= 1'b1;
            o_hresp_ff <= 1'b0;
            o_hrdata_ff <= (addr_phase && !i_hwrite) ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    // pin and control outputs
    reg high_d_ff;
    reg low_d_ff;

    always @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_decoder_in_ff <= 1'b0;
            o_mod_pin_out_ff <= 1'b0;
            o_mod_pin_oe_ff <= 1'b0;
            o_tx_mod_ff <= 1'b0;
            o_direct_modulation_select_ff <= 1'b0;
            o_rx_reset_ff <= 1'b0;
            o_stage_sel_ff <= 1'b0;
            o_second_stage_attenuate_ff <= 1'b0;
            o_first_stage_attenuate_ff <= 1'b0;
            o_follower_test_ff <= 1'b0;
            o_rf_amplitude_test_ff <= 1'b0;
            o_io_test_high_ff <= 1'b0;
            o_io_test_low_ff <= 1'b0;
            o_decoder_test_ff <= 1'b0;
            o_test_mode_ff <= 1'b0;
            o_coder_fast_clock_ff <= 1'b0;
            o_strength_valid_ff <= 1'b0;
            o_osc_ok_ff <= 1'b0;
            o_fifo_irq_set_ff <= 1'b0;
            high_d_ff <= 1'b0;
            low_d_ff <= 1'b0;
        end else begin
            o_decoder_in_ff <= atest_ff[`ATC_KEYING_IN_BIT] ? key_sync_ff : i_demod_subcarrier;
            o_mod_pin_out_ff <= atest_ff[`ATC_SUBC_OUT_BIT] & i_rx_subcarrier;
            o_mod_pin_oe_ff <= atest_ff[`ATC_SUBC_OUT_BIT];
            o_direct_modulation_select_ff <= atest_ff[`ATC_DIRECT_MOD_BIT];
            o_rx_reset_ff <= atest_ff[`ATC_DIRECT_MOD_BIT];
            o_tx_mod_ff <= atest_ff[`ATC_DIRECT_MOD_BIT] & ~atest_ff[`ATC_SUBC_OUT_BIT]
                & mod_sync_ff;
            o_stage_sel_ff <= atest_ff[`ATC_STAGE_SEL_BIT];
            o_second_stage_attenuate_ff <= atest_ff[`ATC_SECOND_ATT_BIT];
            o_first_stage_attenuate_ff <= atest_ff[`ATC_FIRST_ATT_BIT];
            o_follower_test_ff <= atest_ff[`ATC_FOLLOWER_BIT];
            o_rf_amplitude_test_ff <= dtest_ff[`DTC_RF_AMP_BIT];
            o_io_test_high_ff <= dtest_ff[`DTC_IO_HIGH_BIT];
            o_io_test_low_ff <= dtest_ff[`DTC_IO_LOW_BIT];
            o_decoder_test_ff <= dtest_ff[`DTC_DEC_TEST_BIT];
            o_test_mode_ff <= |(dtest_ff & `DTC_STOP_CLR_MASK);
            o_coder_fast_clock_ff <= dtest_ff[`DTC_FAST_CLK_BIT];
            o_strength_valid_ff <= valid_ff;
            o_osc_ok_ff <= osc_ok_ff;
            high_d_ff <= high_ff;
            low_d_ff <= low_ff;
            o_fifo_irq_set_ff <= (high_ff & ~high_d_ff) | (low_ff & ~low_d_ff);
        end
    end

endmodule

/* tb/rssi_test_fifo_status_regs_monitor.sv */
// port-level checks for the strength, test and fifo register group
// assumes one clock domain and the async active-low reset
module rssi_test_fifo_status_regs_monitor (
    // clock and reset
    input logic i_clk_sys,
    input logic i_rst_b,
    // bus and events
    input logic i_hsel,
    input logic [31:0] i_haddr,
    input logic [1:0] i_htrans,
    input logic i_hwrite,
    input logic i_hready,
    input logic i_tx_start,
    input logic i_rx_active,
    input logic i_stop_cond,
    input logic i_rx_subcarrier,
    // design outputs
    input logic [31:0] o_hrdata_ff,
    input logic o_mod_pin_out_ff,
    input logic o_mod_pin_oe_ff,
    input logic o_tx_mod_ff,
    input logic o_direct_modulation_select_ff,
    input logic o_rx_reset_ff,
    input logic o_io_test_high_ff,
    input logic o_io_test_low_ff,
    input logic o_decoder_test_ff,
    input logic o_test_mode_ff,
    input logic o_strength_valid_ff,
    input logic o_fifo_irq_set_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    wire take = i_hsel & i_htrans[1] & i_hready;
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_b);

    a_subc_out_follow: assert property (o_mod_pin_oe_ff |->
        o_mod_pin_out_ff == $past(i_rx_subcarrier)) else $error("subcarrier out wrong");
    a_subc_out_gated: assert property (!o_mod_pin_oe_ff |-> !o_mod_pin_out_ff)
        else $error("mod pin driven while disabled");
    a_direct_rx_reset: assert property (o_direct_modulation_select_ff == o_rx_reset_ff)
        else $error("direct modulation and rx reset differ");
    a_tx_mod_gate: assert property (o_tx_mod_ff |->
        o_direct_modulation_select_ff && !o_mod_pin_oe_ff) else $error("tx mod ungated");
    a_test_mode_or: assert property (o_test_mode_ff ==
        (o_io_test_high_ff | o_io_test_low_ff | o_decoder_test_ff)) else $error("test mode");
    a_stop_clears: assert property (i_stop_cond && !$past(take && i_hwrite) |->
        ##2 !o_test_mode_ff) else $error("stop did not clear test mode");
    a_valid_set: assert property ($rose(i_rx_active) && !i_tx_start |->
        ##[1:3] o_strength_valid_ff) else $error("strength not valid in rx");
    a_valid_clear: assert property (i_tx_start && !i_rx_active && !$past(i_rx_active)
        && !$past(i_rx_active, 2) |-> ##2 !o_strength_valid_ff) else $error("valid not cleared");
    a_irq_pulse: assert property (o_fifo_irq_set_ff |=> !o_fifo_irq_set_ff)
        else $error("fifo irq not a pulse");
    a_fifo_bit7: assert property ($past(take && !i_hwrite && i_haddr[9:0] == 10'h070)
        |-> !o_hrdata_ff[7]) else $error("fifo reserved bit set");

    c_valid: cover property ($rose(o_strength_valid_ff));
    c_irq: cover property (o_fifo_irq_set_ff);
    c_stop: cover property ($fell(o_test_mode_ff));
endmodule

bind rssi_test_fifo_status_regs rssi_test_fifo_status_regs_monitor i_mon (.*);

/* tb/ahb_host_model.sv */
// ahb-lite single-word master standing in for the host controller
// assumes hready is the slave's hreadyout and a free-running clock
module ahb_host_model (
    // clock
    input wire logic i_clk_sys,
    // slave answer
    input wire logic i_hready,
    input wire logic [31:0] i_hrdata,
    // master request
    output logic o_hsel,
    output logic [31:0] o_haddr,
    output logic [1:0] o_htrans,
    output logic o_hwrite,
    output logic [2:0] o_hsize,
    output logic [31:0] o_hwdata
);
    timeunit 1ns;
    timeprecision 1ps;
    assign o_hsize = 3'h2;
    initial begin
        o_hsel = 1'b0;
        o_haddr = 32'h0;
        o_htrans = 2'h0;
        o_hwrite = 1'b0;
        o_hwdata = 32'h0;
    end
    // address phase, then data phase, each held until hready
    task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] q);
        @(posedge i_clk_sys);
        o_hsel <= 1'b1;
        o_haddr <= a;
        o_htrans <= 2'h2;
        o_hwrite <= w;
        do @(posedge i_clk_sys); while (!i_hready);
        o_hsel <= 1'b0;
        o_htrans <= 2'h0;
        o_hwdata <= d;
        do @(posedge i_clk_sys); while (!i_hready);
        q = i_hrdata;
    endtask
endmodule

/* tb/rssi_test_fifo_status_regs_test.sv */
// self-checking bench for the strength, test and fifo register group
// assumes the design header is on the include path
module rssi_test_fifo_status_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk_sys = 0, i_rst_b = 0, i_enable = 1, i_hsel, i_hwrite;
    logic [1:0] i_htrans;
    logic [2:0] i_hsize;
    logic [31:0] i_haddr, i_hwdata, o_hrdata_ff, q;
    logic i_tx_start = 0, i_tx_active = 0, i_rx_active = 0, i_rf_amp_cmd = 0;
    logic i_stop_cond = 0, i_swap_inputs = 0, i_fifo_push = 0, i_fifo_pop = 0;
    logic [2:0] i_in1_env_lvl = 0, i_in2_env_lvl = 0, i_rf_amp_lvl = 0, i_agc_lvl = 0;
    logic i_fifo_reset = 0, i_keying_pin = 0, i_mod_pin = 0, i_rx_subcarrier = 0;
    logic i_demod_subcarrier = 0, o_hreadyout_ff, o_hresp_ff, o_decoder_in_ff;
    logic o_mod_pin_out_ff, o_mod_pin_oe_ff, o_tx_mod_ff, o_direct_modulation_select_ff;
    logic o_rx_reset_ff, o_stage_sel_ff, o_second_stage_attenuate_ff, o_follower_test_ff;
    logic o_first_stage_attenuate_ff, o_rf_amplitude_test_ff, o_io_test_high_ff;
    logic o_io_test_low_ff, o_decoder_test_ff, o_test_mode_ff, o_coder_fast_clock_ff;
    logic o_strength_valid_ff, o_osc_ok_ff, o_fifo_irq_set_ff;
    wire i_hready = o_hreadyout_ff;
    int n_errors = 0, cmp_count = 0;

    rssi_test_fifo_status_regs #(.OSC_SETTLE_CYC(20)) i_dut (.*);
    ahb_host_model i_host (.i_clk_sys(i_clk_sys), .i_hready(i_hready),
        .i_hrdata(o_hrdata_ff), .o_hsel(i_hsel), .o_haddr(i_haddr), .o_htrans(i_htrans),
        .o_hwrite(i_hwrite), .o_hsize(i_hsize), .o_hwdata(i_hwdata));

    initial begin
        forever #20 i_clk_sys = ~i_clk_sys;
    end
    always @(posedge i_clk_sys) begin
        i_rx_subcarrier <= ~i_rx_subcarrier;
    end
    // fifo interrupt event pulses seen
    int n_irq = 0;
    always @(posedge i_clk_sys) begin
        if (o_fifo_irq_set_ff === 1'b1) begin
            n_irq++;
        end
    end

    task automatic test_done;
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask
    task automatic wr(input logic [31:0] a, d);
        i_host.xfer(1'b1, a, d, q);
    endtask
    task automatic rc(input string nm, input logic [31:0] a, exp);
        i_host.xfer(1'b0, a, 32'h0, q);
        chk(nm, q, exp);
    endtask
    // one-cycle event: 0 tx start, 1 stop, 2 fifo reset
    task automatic ev(input int k);
        @(posedge i_clk_sys);
        i_tx_start <= (k == 0);
        i_stop_cond <= (k == 1);
        i_fifo_reset <= (k == 2);
        @(posedge i_clk_sys);
        i_tx_start <= 1'b0;
        i_stop_cond <= 1'b0;
        i_fifo_reset <= 1'b0;
    endtask
    task automatic lv(input logic [2:0] a, b);
        @(posedge i_clk_sys);
        i_in1_env_lvl <= a;
        i_in2_env_lvl <= b;
        tick(2);
    endtask
    task automatic fop(input int n, input logic ps, pp);
        repeat (n) begin
            @(posedge i_clk_sys);
            i_fifo_push <= ps;
            i_fifo_pop <= pp;
        end
        @(posedge i_clk_sys);
        i_fifo_push <= 1'b0;
        i_fifo_pop <= 1'b0;
    endtask

    initial begin
        repeat (20000) @(posedge i_clk_sys);
        n_errors++;
        test_done;
    end

    initial begin
        tick(12);
        chk("ready in reset", o_hreadyout_ff, 32'h0);
        i_rst_b <= 1'b1;
        tick(3);
        rc("analog test", 32'h68, 32'h0);
        rc("digital test", 32'h6c, 32'h0);
        rc("fifo status", 32'h70, 32'h0);
        chk("osc early", o_osc_ok_ff, 32'h0);
        chk("bus response", {o_hreadyout_ff, o_hresp_ff}, 32'h2);
        wr(32'h68, 32'h5c);
        rc("analog test", 32'h68, 32'h5c);
        tick(2);
        #1;
        chk("mod pin oe", o_mod_pin_oe_ff, 32'h1);
        chk("stage controls", {o_stage_sel_ff, o_second_stage_attenuate_ff,
            o_first_stage_attenuate_ff, o_direct_modulation_select_ff}, 32'he);
        @(posedge i_clk_sys);
        i_keying_pin <= 1'b1;
        i_mod_pin <= 1'b1;
        i_agc_lvl <= 3'h5;
        wr(32'h68, 32'ha3);
        tick(5);
        #1;
        chk("decoder in", o_decoder_in_ff, 32'h1);
        chk("direct tx mod", {o_tx_mod_ff, o_rx_reset_ff, o_follower_test_ff}, 32'h7);
        chk("osc ok pin", o_osc_ok_ff, 32'h1);
        rc("agc observe", 32'h3c, 32'h45);
        wr(32'h68, 32'h0);
        wr(32'h6c, 32'hff);
        rc("digital test", 32'h6c, 32'h8f);
        tick(2);
        #1;
        chk("test outputs", {o_test_mode_ff, o_coder_fast_clock_ff,
            o_rf_amplitude_test_ff, o_io_test_high_ff, o_io_test_low_ff,
            o_decoder_test_ff}, 32'h3f);
        chk("decoder normal", o_decoder_in_ff, 32'h0);
        ev(1);
        rc("digital after stop", 32'h6c, 32'h81);
        wr(32'h6c, 32'h0);
        wr(32'h3c, 32'hff);
        wr(32'h70, 32'hff);
        wr(32'h100, 32'hff);
        rc("unmapped", 32'h100, 32'h0);
        rc("fifo ignores write", 32'h70, 32'h0);
        lv(3'h3, 3'h6);
        @(posedge i_clk_sys);
        i_rx_active <= 1'b1;
        lv(3'h5, 3'h2);
        lv(3'h1, 3'h1);
        @(posedge i_clk_sys);
        i_rx_active <= 1'b0;
        lv(3'h7, 3'h7);
        rc("peak hold", 32'h3c, 32'h75);
        ev(0);
        rc("cleared by tx", 32'h3c, 32'h40);
        lv(3'h2, 3'h4);
        @(posedge i_clk_sys);
        i_rx_active <= 1'b1;
        i_swap_inputs <= 1'b1;
        tick(3);
        i_rx_active <= 1'b0;
        rc("swapped inputs", 32'h3c, 32'h54);
        ev(0);
        @(posedge i_clk_sys);
        i_swap_inputs <= 1'b0;
        i_rf_amp_lvl <= 3'h7;
        i_rf_amp_cmd <= 1'b1;
        tick(3);
        i_rf_amp_cmd <= 1'b0;
        i_host.xfer(1'b0, 32'h3c, 32'h0, q);
        chk("rf amplitude", q & 32'h47, 32'h47);
        ev(0);
        @(posedge i_clk_sys);
        i_rx_active <= 1'b1;
        fop(8, 1'b1, 1'b0);
        rc("fifo eight", 32'h70, 32'h07);
        fop(1, 1'b1, 1'b0);
        rc("fifo high", 32'h70, 32'h48);
        fop(8, 1'b1, 1'b0);
        rc("fifo overflow", 32'h70, 32'h5f);
        ev(2);
        @(posedge i_clk_sys);
        i_rx_active <= 1'b0;
        i_tx_active <= 1'b1;
        fop(4, 1'b1, 1'b0);
        fop(1, 1'b0, 1'b1);
        rc("fifo low", 32'h70, 32'h22);
        @(posedge i_clk_sys);
        i_tx_active <= 1'b0;
        wr(32'h68, 32'h10);
        @(posedge i_clk_sys);
        i_enable <= 1'b0;
        tick(4);
        i_enable <= 1'b1;
        tick(3);
        rc("enable clears", 32'h68, 32'h0);
        rc("osc restart", 32'h3c, 32'h0);
        chk("fifo irq pulses", n_irq, 32'h3);
        test_done;
    end
endmodule
